// File: common/ifra_pkg.sv
// constants and types for the indirect framer register window
// What this block does
// - queue read returns vector; resets to ones
// - transmit select holds port field 12:8
// - transmit port steps on data access
// - transmit address steps on data access
// - transmit select holds address bits 3:0
// - transmit data access reaches selected framer register
// - receive select holds port field 12:8
// - receive port steps on data access
// - receive address steps on data access
// - receive select holds address bits 6:0
// - receive data access reaches selected register
// - link port 0..27, 28 is alarm channel
// - link port steps when bit 15 set
// - data access touches only selected port
// - link address field 4:0, steps too
// - queue clear empties pending vectors
package ifra_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // register byte offsets
  localparam logic [8:0] OFS_IVQ = 9'h10c;
  localparam logic [8:0] OFS_TX_SEL = 9'h110;
  localparam logic [8:0] OFS_TX_DAT = 9'h114;
  localparam logic [8:0] OFS_RX_SEL = 9'h118;
  localparam logic [8:0] OFS_RX_DAT = 9'h11c;
  localparam logic [8:0] OFS_DL_SEL = 9'h120;
  localparam logic [8:0] OFS_DL_DAT = 9'h124;

  // select register field positions
  localparam int FRM_AIP_BIT = 14;
  localparam int DL_AIP_BIT = 15;
  localparam int AIA_BIT = 7;
  localparam int PORT_LSB = 8;
  localparam int PORT_W = 5;
  localparam int SEL_ADDR_W = 7;
  localparam int TX_ADDR_W = 4;
  localparam int RX_ADDR_W = 7;
  localparam int DL_ADDR_W = 5;

  // highest legal port numbers
  localparam logic [4:0] FRM_PORT_MAX = 5'h1b;
  localparam logic [4:0] DL_PORT_MAX = 5'h1c;

  // reset values
  localparam logic [15:0] IVQ_RESET = 16'hffff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // interrupt vector queue size
  localparam int IVQ_DEPTH = 16;
  localparam int IVQ_PTR_W = 4;

  typedef enum logic [1:0] {
    TGT_TX = 2'b00,
    TGT_RX = 2'b01,
    TGT_DL = 2'b10
  } ifra_tgt_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } ifra_fsm_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ifra_host_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } ifra_host_rsp_t;

  typedef struct packed {
    logic port_step;
    logic addr_step;
    logic [PORT_W-1:0] port;
    logic [SEL_ADDR_W-1:0] addr;
  } ifra_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [PORT_W-1:0] port;
    logic [SEL_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ifra_ind_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } ifra_ind_rsp_t;

endpackage : ifra_pkg

// File: design/ifra_vec_queue.sv
// interrupt vector queue, first in first out
`timescale 1ns/100ps
`default_nettype none
module ifra_vec_queue
  import ifra_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic push_i,
  input wire logic [DATA_W-1:0] push_data_i,
  input wire logic pop_i,
  input wire logic clear_i,
  output logic [DATA_W-1:0] head_o,
  output logic empty_o,
  output logic full_o
);

  typedef struct packed {
    logic [IVQ_DEPTH-1:0][DATA_W-1:0] mem;
    logic [IVQ_PTR_W-1:0] wr_ptr;
    logic [IVQ_PTR_W-1:0] rd_ptr;
    logic [IVQ_PTR_W:0] count;
  } ifra_q_st_t;

  ifra_q_st_t st_ff;
  ifra_q_st_t nxt_st;
  logic do_push;
  logic do_pop;

  // a push in the clearing cycle still lands in the emptied queue
  always_comb begin
    nxt_st = st_ff;
    do_pop = pop_i && (st_ff.count != '0) && !clear_i;
    do_push = push_i && ((st_ff.count != (IVQ_PTR_W+1)'(IVQ_DEPTH)) || do_pop || clear_i);
    if (clear_i) begin
      nxt_st.rd_ptr = '0;
      nxt_st.wr_ptr = '0;
      nxt_st.count = '0;
    end
    if (do_pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
    end
    if (do_push) begin
      nxt_st.mem[nxt_st.wr_ptr] = push_data_i;
      nxt_st.wr_ptr = nxt_st.wr_ptr + 1'b1;
    end
    if (!clear_i) begin
      nxt_st.count = st_ff.count + (IVQ_PTR_W+1)'(do_push) - (IVQ_PTR_W+1)'(do_pop);
    end else begin
      nxt_st.count = (IVQ_PTR_W+1)'(do_push);
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign head_o = st_ff.mem[st_ff.rd_ptr];
  assign empty_o = (st_ff.count == '0);
  assign full_o = (st_ff.count == (IVQ_PTR_W+1)'(IVQ_DEPTH));

endmodule : ifra_vec_queue
`default_nettype wire

// File: design/ifra_reg_window.sv
// host register window with indirect framer and data link access
`timescale 1ns/100ps
`default_nettype none
module ifra_reg_window
  import ifra_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // host register port
  input wire ifra_host_req_t host_req_i,
  output ifra_host_rsp_t host_rsp_o,
  output logic host_busy_o,
  // transmit framer side
  output ifra_ind_req_t tx_req_o,
  input wire ifra_ind_rsp_t tx_rsp_i,
  // receive framer side
  output ifra_ind_req_t rx_req_o,
  input wire ifra_ind_rsp_t rx_rsp_i,
  // facility data link side
  output ifra_ind_req_t dl_req_o,
  input wire ifra_ind_rsp_t dl_rsp_i,
  // interrupt vector sources
  input wire logic vec_push_i,
  input wire logic [DATA_W-1:0] vector_value_i,
  input wire logic queue_clear_i,
  output logic local_irq_line_o,
  output logic queue_full_o
);

  typedef struct packed {
    ifra_fsm_t fsm;
    ifra_tgt_t tgt;
    logic pend_rd;
    logic busy;
    logic irq;
    logic full;
    ifra_host_rsp_t rsp;
    ifra_sel_t [2:0] sel;
    ifra_ind_req_t [2:0] ind;
  } ifra_st_t;

  ifra_st_t st_ff;
  ifra_st_t nxt_st;
  ifra_ind_rsp_t [2:0] ind_rsp;
  logic q_pop;
  logic q_push;
  logic q_clear;
  logic [DATA_W-1:0] q_head;
  logic q_empty;
  logic q_full;
  logic host_acc;

  // hit test for a select register, returns {hit, target}
  function automatic logic [2:0] sel_hit(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      OFS_TX_SEL: r = {1'b1, TGT_TX};
      OFS_RX_SEL: r = {1'b1, TGT_RX};
      OFS_DL_SEL: r = {1'b1, TGT_DL};
      default: r = 3'h0;
    endcase
    return r;
  endfunction : sel_hit

  // hit test for a data register, returns {hit, target}
  function automatic logic [2:0] dat_hit(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      OFS_TX_DAT: r = {1'b1, TGT_TX};
      OFS_RX_DAT: r = {1'b1, TGT_RX};
      OFS_DL_DAT: r = {1'b1, TGT_DL};
      default: r = 3'h0;
    endcase
    return r;
  endfunction : dat_hit

  // address field width mask per target
  function automatic logic [SEL_ADDR_W-1:0] addr_mask(input ifra_tgt_t t);
    logic [SEL_ADDR_W-1:0] m;
    m = '0;
    unique case (t)
      TGT_TX: m = SEL_ADDR_W'((1 << TX_ADDR_W) - 1);
      TGT_RX: m = SEL_ADDR_W'((1 << RX_ADDR_W) - 1);
      TGT_DL: m = SEL_ADDR_W'((1 << DL_ADDR_W) - 1);
      default: m = '0;
    endcase
    return m;
  endfunction : addr_mask

  // compose select register read value, reserved bits zero
  function automatic logic [DATA_W-1:0] sel_read(input ifra_sel_t s, input ifra_tgt_t t);
    logic [DATA_W-1:0] r;
    r = '0;
    r[PORT_LSB +: PORT_W] = s.port;
    r[AIA_BIT] = s.addr_step;
    r[SEL_ADDR_W-1:0] = s.addr & addr_mask(t);
    if (t == TGT_DL) begin
      r[DL_AIP_BIT] = s.port_step;
    end else begin
      r[FRM_AIP_BIT] = s.port_step;
    end
    return r;
  endfunction : sel_read

  // decode a host write into select fields, reserved bits dropped
  function automatic ifra_sel_t sel_write(input logic [DATA_W-1:0] d, input ifra_tgt_t t);
    ifra_sel_t s;
    s.port = d[PORT_LSB +: PORT_W];
    s.addr_step = d[AIA_BIT];
    s.addr = d[SEL_ADDR_W-1:0] & addr_mask(t);
    if (t == TGT_DL) begin
      s.port_step = d[DL_AIP_BIT];
    end else begin
      s.port_step = d[FRM_AIP_BIT];
    end
    return s;
  endfunction : sel_write

  // advance port and address after a completed data access
  function automatic ifra_sel_t sel_step(input ifra_sel_t s, input ifra_tgt_t t);
    ifra_sel_t n;
    logic [PORT_W-1:0] pmax;
    n = s;
    pmax = (t == TGT_DL) ? DL_PORT_MAX : FRM_PORT_MAX;
    if (s.port_step) begin
      if (s.port >= pmax) begin
        n.port = '0;
      end else begin
        n.port = s.port + 1'b1;
      end
    end
    if (s.addr_step) begin
      n.addr = (s.addr + 1'b1) & addr_mask(t);
    end
    return n;
  endfunction : sel_step

  // gather the answers of the three indirect targets
  assign ind_rsp[TGT_TX] = tx_rsp_i;
  assign ind_rsp[TGT_RX] = rx_rsp_i;
  assign ind_rsp[TGT_DL] = dl_rsp_i;

  assign host_acc = host_req_i.rd || host_req_i.wr;
  assign q_push = vec_push_i;
  assign q_clear = queue_clear_i;

  // vector queue feeding the interrupt queue register
  ifra_vec_queue u_vec_queue (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .push_i(q_push),
    .push_data_i(vector_value_i),
    .pop_i(q_pop),
    .clear_i(q_clear),
    .head_o(q_head),
    .empty_o(q_empty),
    .full_o(q_full)
  );

  // register access sequencing and indirect request control
  always_comb begin
    logic [2:0] sh;
    logic [2:0] dh;
    ifra_tgt_t t;
    sh = sel_hit(host_req_i.addr);
    dh = dat_hit(host_req_i.addr);
    t = ifra_tgt_t'(dh[1:0]);
    nxt_st = st_ff;
    q_pop = 1'b0;
    nxt_st.rsp.valid = 1'b0;
    nxt_st.irq = !q_empty && !q_clear;
    nxt_st.full = q_full;
    unique case (st_ff.fsm)
      ST_IDLE: begin
        if (host_acc && sh[2]) begin
          if (host_req_i.wr) begin
            nxt_st.sel[sh[1:0]] = sel_write(host_req_i.wdata, ifra_tgt_t'(sh[1:0]));
          end else begin
            nxt_st.rsp.valid = 1'b1;
            nxt_st.rsp.data = sel_read(st_ff.sel[sh[1:0]], ifra_tgt_t'(sh[1:0]));
          end
        end else if (host_acc && dh[2]) begin
          // one request, only to the selected port of one target
          nxt_st.ind[t].valid = 1'b1;
          nxt_st.ind[t].write = host_req_i.wr;
          nxt_st.ind[t].port = st_ff.sel[t].port;
          nxt_st.ind[t].addr = st_ff.sel[t].addr & addr_mask(t);
          nxt_st.ind[t].wdata = host_req_i.wdata;
          nxt_st.tgt = t;
          nxt_st.pend_rd = host_req_i.rd;
          nxt_st.busy = 1'b1;
          nxt_st.fsm = ST_WAIT;
        end else if (host_req_i.rd && (host_req_i.addr == OFS_IVQ)) begin
          // reading the queue pops one vector
          nxt_st.rsp.valid = 1'b1;
          nxt_st.rsp.data = q_empty ? IVQ_RESET : q_head;
          q_pop = !q_empty;
        end else if (host_req_i.rd) begin
          nxt_st.rsp.valid = 1'b1;
          nxt_st.rsp.data = UNMAPPED_READ;
        end
      end
      ST_WAIT: begin
        if (ind_rsp[st_ff.tgt].ack) begin
          nxt_st.ind[st_ff.tgt].valid = 1'b0;
          nxt_st.ind[st_ff.tgt].write = 1'b0;
          if (st_ff.pend_rd) begin
            nxt_st.rsp.valid = 1'b1;
            nxt_st.rsp.data = ind_rsp[st_ff.tgt].rdata;
          end
          // stepping only after the access used the old selection
          nxt_st.sel[st_ff.tgt] = sel_step(st_ff.sel[st_ff.tgt], st_ff.tgt);
          nxt_st.pend_rd = 1'b0;
          nxt_st.busy = 1'b0;
          nxt_st.fsm = ST_IDLE;
        end
      end
    endcase
  end

  // state register, reset values from the package
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.fsm <= ST_IDLE;
      st_ff.tgt <= TGT_TX;
      st_ff.rsp.data <= REG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output straight from the state register
  assign host_rsp_o = st_ff.rsp;
  assign host_busy_o = st_ff.busy;
  assign tx_req_o = st_ff.ind[TGT_TX];
  assign rx_req_o = st_ff.ind[TGT_RX];
  assign dl_req_o = st_ff.ind[TGT_DL];
  assign local_irq_line_o = st_ff.irq;
  assign queue_full_o = st_ff.full;

endmodule : ifra_reg_window
`default_nettype wire

// File: sim/ifra_frm_model.sv
// behavioural indirect target for one framer or data link block
`timescale 1ns/100ps
`default_nettype none
module ifra_frm_model
  import ifra_pkg::*;
#(
  parameter logic [3:0] TAG = 4'h0
)
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire ifra_ind_req_t req_i,
  output ifra_ind_rsp_t rsp_o
);
  logic ack_ff;
  logic [1:0] wait_ff;
  logic [15:0] rd;
  // ack at once or after a three cycle stall
  always @(posedge clk_sys_i) begin
    ack_ff <= 1'b0;
    if (!resetn_i) begin
      wait_ff <= 2'h0;
    end else if (req_i.valid && !ack_ff) begin
      if (!slow_i || wait_ff == 2'h3) begin
        ack_ff <= 1'b1;
        wait_ff <= 2'h0;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
  // read data shows port and address, scrambled outside the ack cycle
  assign rd = {TAG, req_i.port, req_i.addr};
  assign rsp_o = '{ack: ack_ff, rdata: ack_ff ? rd : ~rd};
endmodule : ifra_frm_model
`default_nettype wire

// File: sim/ifra_reg_window_properties.sv
// assertions on the host window, target links and vector queue
`timescale 1ns/100ps
`default_nettype none
module ifra_reg_window_properties
  import ifra_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire ifra_host_req_t host_req_i,
  input wire ifra_host_rsp_t host_rsp_o,
  input wire logic host_busy_o,
  input wire ifra_ind_req_t tx_req_o,
  input wire ifra_ind_rsp_t tx_rsp_i,
  input wire ifra_ind_req_t rx_req_o,
  input wire ifra_ind_rsp_t rx_rsp_i,
  input wire ifra_ind_req_t dl_req_o,
  input wire ifra_ind_rsp_t dl_rsp_i,
  input wire logic vec_push_i,
  input wire logic [DATA_W-1:0] vector_value_i,
  input wire logic queue_clear_i,
  input wire logic local_irq_line_o,
  input wire logic queue_full_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  // requests taken this cycle
  wire logic take_rd = host_req_i.rd && !host_req_i.wr && !host_busy_o;
  wire logic take_any = (host_req_i.rd || host_req_i.wr) && !host_busy_o;
  property p_tx_sel_rsv;
    take_rd && host_req_i.addr == OFS_TX_SEL
      |=> host_rsp_o.valid && (host_rsp_o.data & 16'ha070) == 16'h0000;
  endproperty
  a_tx_sel_rsv: assert property (p_tx_sel_rsv) else $error("tx select reserved bit set");
  property p_dl_sel_rsv;
    take_rd && host_req_i.addr == OFS_DL_SEL
      |=> host_rsp_o.valid && (host_rsp_o.data & 16'h6060) == 16'h0000;
  endproperty
  a_dl_sel_rsv: assert property (p_dl_sel_rsv) else $error("dl select reserved bit set");
  property p_tx_req;
    take_any && host_req_i.addr == OFS_TX_DAT
      |=> tx_req_o.valid && host_busy_o && tx_req_o.write == $past(host_req_i.wr);
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request not raised");
  property p_tx_hold;
    tx_req_o.valid && !tx_rsp_i.ack |=> tx_req_o.valid && $stable(tx_req_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx request changed before ack");
  property p_one_target;
    $onehot0({tx_req_o.valid, rx_req_o.valid, dl_req_o.valid});
  endproperty
  a_one_target: assert property (p_one_target) else $error("two targets addressed");
  property p_dl_end;
    dl_req_o.valid && dl_rsp_i.ack |=> !dl_req_o.valid && !host_busy_o;
  endproperty
  a_dl_end: assert property (p_dl_end) else $error("dl access not ended by ack");
  property p_irq_push;
    vec_push_i ##1 !queue_clear_i |=> local_irq_line_o;
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("irq not raised after push");
  property p_clear;
    queue_clear_i && !vec_push_i |-> ##2 !local_irq_line_o;
  endproperty
  a_clear: assert property (p_clear) else $error("irq left after clear");
  // main scenarios reached
  c_tx_ack: cover property (tx_req_o.valid && tx_rsp_i.ack);
  c_full: cover property (queue_full_o);
  c_alarm: cover property (dl_req_o.valid && dl_req_o.port == 5'h1c);
endmodule : ifra_reg_window_properties
bind ifra_reg_window ifra_reg_window_properties u_props (.*);
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the indirect framer register window
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ifra_pkg::*;
  typedef struct packed {
    logic [8:0] wa;
    logic [15:0] wv;
    logic [8:0] ra;
    logic [15:0] e;
  } ifra_row_t;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic slow = 1'b0;
  ifra_host_req_t hreq = '0;
  ifra_host_rsp_t hrsp;
  logic busy, irq, qfull;
  ifra_ind_req_t txq, rxq, dlq;
  ifra_ind_rsp_t txr, rxr, dlr;
  logic push = 1'b0;
  logic [15:0] vval = 16'h0000;
  logic qclr = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] q;
  logic [31:0] last_wr;
  logic [8:0] sel_ofs [3] = '{OFS_TX_SEL, OFS_RX_SEL, OFS_DL_SEL};
  // write, read address, expected read
  ifra_row_t rows [15] = '{
    {9'h110, 16'hffff, 9'h110, 16'h5f8f},
    {9'h118, 16'hffff, 9'h118, 16'h5fff},
    {9'h120, 16'hffff, 9'h120, 16'h9f9f},
    {9'h100, 16'h1234, 9'h100, 16'h0000},
    {9'h10c, 16'h1234, 9'h10c, 16'hffff},
    {9'h110, 16'h5b8f, 9'h114, 16'had8f},
    {9'h100, 16'h0000, 9'h114, 16'ha000},
    {9'h100, 16'h0000, 9'h110, 16'h4181},
    {9'h118, 16'h03ff, 9'h11c, 16'hb1ff},
    {9'h100, 16'h0000, 9'h11c, 16'hb180},
    {9'h118, 16'h5b00, 9'h11c, 16'hbd80},
    {9'h100, 16'h0000, 9'h11c, 16'hb000},
    {9'h120, 16'h9c9f, 9'h124, 16'hce1f},
    {9'h100, 16'h0000, 9'h124, 16'hc000},
    {9'h100, 16'h0000, 9'h120, 16'h8181}};
  ifra_reg_window u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .host_req_i(hreq),
    .host_rsp_o(hrsp), .host_busy_o(busy), .tx_req_o(txq), .tx_rsp_i(txr), .rx_req_o(rxq),
    .rx_rsp_i(rxr), .dl_req_o(dlq), .dl_rsp_i(dlr), .vec_push_i(push), .vector_value_i(vval),
    .queue_clear_i(qclr), .local_irq_line_o(irq), .queue_full_o(qfull));
  ifra_frm_model #(.TAG(4'ha)) u_tx (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .slow_i(slow), .req_i(txq), .rsp_o(txr));
  ifra_frm_model #(.TAG(4'hb)) u_rx (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .slow_i(slow), .req_i(rxq), .rsp_o(rxr));
  ifra_frm_model #(.TAG(4'hc)) u_dl (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .slow_i(slow), .req_i(dlq), .rsp_o(dlr));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // last write seen by the transmit framer
  always @(posedge clk_sys_i) begin
    if (txr.ack && txq.write) last_wr <= {4'h0, txq.port, txq.addr, txq.wdata};
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one host access; waits for the read answer or for busy to drop
  task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d);
    q = 'x;
    hreq = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge clk_sys_i);
    hreq = '0;
    for (int k = 0; k < 20; k++) begin
      if (!w && hrsp.valid) begin
        q = 32'(hrsp.data);
        break;
      end
      if (w && !busy) break;
      @(negedge clk_sys_i);
    end
    // idle gap so the next call never drives the request in this time step
    @(negedge clk_sys_i);
  endtask : acc
  task automatic final_report();
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 15; i++) begin
      slow = i[0];
      acc(1'b1, rows[i].wa, rows[i].wv);
      acc(1'b0, rows[i].ra, 16'h0000);
      chk("row read", q, 32'(rows[i].e));
    end
    // forwarded write to port 5 register 2, no stepping
    acc(1'b1, OFS_TX_SEL, 16'h0502);
    acc(1'b1, OFS_TX_DAT, 16'h1234);
    chk("tx write", last_wr, 32'h02821234);
    acc(1'b0, OFS_TX_SEL, 16'h0000);
    chk("tx select kept", q, 32'h0502);
    // fill the queue past full, then drain it in order
    for (int i = 0; i < 17; i++) begin
      vval = 16'h0100 + 16'(i);
      push = 1'b1;
      @(negedge clk_sys_i);
    end
    push = 1'b0;
    @(negedge clk_sys_i);
    chk("queue full", 32'(qfull), 32'h1);
    for (int i = 0; i < 17; i++) begin
      acc(1'b0, OFS_IVQ, 16'h0000);
      chk("vector", q, (i < 16) ? 32'h0100 + 32'(i) : 32'hffff);
    end
    @(negedge clk_sys_i);
    chk("irq idle", 32'(irq), 32'h0);
    // clear drops a pending vector
    vval = 16'h0042;
    push = 1'b1;
    @(negedge clk_sys_i);
    push = 1'b0;
    qclr = 1'b1;
    @(negedge clk_sys_i);
    qclr = 1'b0;
    @(negedge clk_sys_i);
    chk("irq cleared", 32'(irq), 32'h0);
    acc(1'b0, OFS_IVQ, 16'h0000);
    chk("empty vector", q, 32'hffff);
    // second reset restores the select registers
    resetn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, sel_ofs[i], 16'h0000);
      chk("select reset", q, 32'h0);
    end
    final_report();
  end
endmodule : tb
`default_nettype wire
